// *** hw/cctr_top.sv ***
// Control register, emitter-two timing registers and pulse sequencer behind the serial port.
//
// Function
// - Control bits: soft reset, diagnostics, count clear, readback.
// - Control register at 00h, resets to zero.
// - Counts are 4 MHz cycles up to period.
// - Counter equals sample start: window opens.
// - Counter equals sample end: window closes.
// - Counter equals on-count at 03h: emitter on.
// - Counter equals off-count: emitter off.
// - Register 05h marks ambient sample start.
// - Compares referenced to the pulse period register.
// - Ambient start compares like other counts.
module cctr_top #(
    parameter int DIAG_LEN = cctr_pkg::DIAG_CYCLES
) (
    input  wire logic                         CLOCK,
    input  wire logic                         RESET_N,
    input  wire logic                         SPI_CLK,
    input  wire logic                         SPI_CS_N,
    input  wire logic                         SPI_MOSI,
    output logic                              SPI_MISO,
    output logic                              SPI_MISO_OE,
    input  wire logic [cctr_pkg::COUNT_W-1:0] PULSE_PERIOD_COUNT,
    input  wire logic [cctr_pkg::FAULT_W-1:0] FAULT_INPUTS,
    output logic [cctr_pkg::FAULT_W-1:0]      FAULT_STATUS,
    output logic                              DIAG_BUSY,
    output logic [cctr_pkg::COUNT_W-1:0]      TIMER_COUNT,
    output logic                              PERIOD_START,
    output logic                              CH2_SAMPLE,
    output logic                              CH2_EMITTER_ON,
    output logic                              CH2_AMBIENT_START
);

    // ------------------------------------------------------------------
    // Link side.
    // ------------------------------------------------------------------

    logic [cctr_pkg::ADDR_W-1:0] link_addr;
    logic                        link_addr_toggle;
    cctr_pkg::cctr_frame_t       link_frame;
    logic                        link_frame_toggle;
    logic [cctr_pkg::DATA_W-1:0] rd_data_reg;

    // Only words and toggles leave this domain.
    // The serial front end owns everything clocked by the link clock.
    cctr_spi_link u_link (
        .spi_clk      (SPI_CLK),
        .reset_n      (RESET_N),
        .cs_n         (SPI_CS_N),
        .mosi         (SPI_MOSI),
        .rd_data      (rd_data_reg),
        .addr_word    (link_addr),
        .addr_toggle  (link_addr_toggle),
        .frame_word   (link_frame),
        .frame_toggle (link_frame_toggle),
        .miso         (SPI_MISO),
        .miso_oe      (SPI_MISO_OE)
    );

    // ------------------------------------------------------------------
    // Crossing of link events and fault pins into the system clock.
    // ------------------------------------------------------------------

    logic                         addr_sync1_reg;
    logic                         addr_sync2_reg;
    logic                         addr_seen_reg;
    logic                         frame_sync1_reg;
    logic                         frame_sync2_reg;
    logic                         frame_seen_reg;
    logic [cctr_pkg::FAULT_W-1:0] fault_sync1_reg;
    logic [cctr_pkg::FAULT_W-1:0] fault_sync2_reg;
    wire                          addr_event;
    wire                          frame_event;

    // Each toggle passes two flops; only the second one feeds the edge detector.
    // A toggle loses no event on a bursty link.
    // Fault pins are unclocked, so they pass
    // the same two flops before any use.
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            addr_sync1_reg  <= 1'b0;
            addr_sync2_reg  <= 1'b0;
            addr_seen_reg   <= 1'b0;
            frame_sync1_reg <= 1'b0;
            frame_sync2_reg <= 1'b0;
            frame_seen_reg  <= 1'b0;
            fault_sync1_reg <= '0;
            fault_sync2_reg <= '0;
        end else begin
            addr_sync1_reg  <= link_addr_toggle;
            addr_sync2_reg  <= addr_sync1_reg;
            addr_seen_reg   <= addr_sync2_reg;
            frame_sync1_reg <= link_frame_toggle;
            frame_sync2_reg <= frame_sync1_reg;
            frame_seen_reg  <= frame_sync2_reg;
            fault_sync1_reg <= FAULT_INPUTS;
            fault_sync2_reg <= fault_sync1_reg;
        end
    end

    // The captured words are stable for a whole frame after their toggle flips.
    // The words need no flops of their own:
    // they stand for cycles before the event.
    assign addr_event  = addr_sync2_reg ^ addr_seen_reg;
    assign frame_event = frame_sync2_reg ^ frame_seen_reg;

    // ------------------------------------------------------------------
    // Register decode.
    // ------------------------------------------------------------------

    logic [cctr_pkg::CTRL_W-1:0]  ctrl_reg;
    logic [cctr_pkg::COUNT_W-1:0] timing_reg [cctr_pkg::TIMING_FIRST:cctr_pkg::TIMING_LAST];
    wire                          read_enable;
    wire                          count_clear;
    wire                          wr_ctrl;
    wire                          soft_reset;
    wire                          diag_launch;
    wire                          frame_is_read;
    wire                          addr_is_read;
    logic [cctr_pkg::DATA_W-1:0]  rd_mux;

    // Control register bits as seen by the block.
    // Both are levels that software owns.
    assign read_enable = ctrl_reg[cctr_pkg::BIT_READ_ENABLE];
    assign count_clear = ctrl_reg[cctr_pkg::BIT_COUNT_CLEAR];

    // Address 00h is always a write, so software can always turn readback off again.
    // With readback on, a timing write needs
    // readback switched off first.
    assign addr_is_read  = read_enable && (link_addr != cctr_pkg::ADDR_MAIN_CONTROL);
    assign frame_is_read = read_enable && (link_frame.addr != cctr_pkg::ADDR_MAIN_CONTROL);
    assign wr_ctrl       = frame_event && (link_frame.addr == cctr_pkg::ADDR_MAIN_CONTROL);
    assign soft_reset    = wr_ctrl && link_frame.data[cctr_pkg::BIT_SOFT_RESET];
    assign diag_launch   = wr_ctrl && link_frame.data[cctr_pkg::BIT_DIAG_LAUNCH] && !soft_reset;

    // Read selection; the upper byte of a timing register always reads zero.
    // Unmapped addresses read as zero.
    always_comb begin
        rd_mux = '0;
        if (link_addr >= cctr_pkg::ADDR_CH2_SAMPLE_START && link_addr <= cctr_pkg::ADDR_CH2_AMBIENT_START) begin
            rd_mux[cctr_pkg::COUNT_W-1:0] = timing_reg[link_addr[2:0]];
        end
    end

    // Read data is prepared as soon as the address byte lands; disabled reads return zero.
    // The word must be ready within half a
    // link period of the address byte.
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            rd_data_reg <= '0;
        end else if (addr_event) begin
            rd_data_reg <= addr_is_read ? rd_mux : '0;
        end
    end

    // ------------------------------------------------------------------
    // Diagnostic sequence.
    // ------------------------------------------------------------------

    cctr_pkg::cctr_diag_state_t diag_state_reg;
    logic [cctr_pkg::DIAG_W-1:0] diag_cnt_reg;
    wire                         diag_done;

    // The check lasts DIAG_LEN system cycles.
    assign diag_done = (diag_state_reg == cctr_pkg::DIAG_RUN) &&
                       (diag_cnt_reg == cctr_pkg::DIAG_W'(DIAG_LEN - 1));

    // A launch while running restarts the check; soft reset aborts it.
    // Faults are taken once, at the end, so a
    // passing fault between is not latched.
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            diag_state_reg <= cctr_pkg::DIAG_IDLE;
            diag_cnt_reg   <= '0;
            FAULT_STATUS   <= '0;
            DIAG_BUSY      <= 1'b0;
        end else if (soft_reset) begin
            diag_state_reg <= cctr_pkg::DIAG_IDLE;
            diag_cnt_reg   <= '0;
            FAULT_STATUS   <= '0;
            DIAG_BUSY      <= 1'b0;
        end else if (diag_launch) begin
            diag_state_reg <= cctr_pkg::DIAG_RUN;
            diag_cnt_reg   <= '0;
            DIAG_BUSY      <= 1'b1;
        end else begin
            unique case (diag_state_reg)
                cctr_pkg::DIAG_IDLE: begin
                    diag_cnt_reg <= '0;
                end
                cctr_pkg::DIAG_RUN: begin
                    diag_cnt_reg <= diag_cnt_reg + 16'h0001;
                    if (diag_done) begin
                        FAULT_STATUS   <= fault_sync2_reg;
                        diag_state_reg <= cctr_pkg::DIAG_IDLE;
                        DIAG_BUSY      <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Control and timing registers.
    // ------------------------------------------------------------------

    // Next value of the control register.
    logic [cctr_pkg::CTRL_W-1:0] ctrl_next;

    // The soft reset bit is never stored; the diagnostic bit mirrors the running check.
    // Only a soft reset write can stop a running check.
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next[cctr_pkg::BIT_READ_ENABLE] = link_frame.data[cctr_pkg::BIT_READ_ENABLE];
            ctrl_next[cctr_pkg::BIT_COUNT_CLEAR] = link_frame.data[cctr_pkg::BIT_COUNT_CLEAR];
        end
        ctrl_next[cctr_pkg::BIT_SOFT_RESET]  = 1'b0;
        ctrl_next[cctr_pkg::BIT_DIAG_LAUNCH] = diag_launch ||
                                               ((diag_state_reg == cctr_pkg::DIAG_RUN) && !diag_done);
    end

    // Control register at 00h; soft reset returns it to zero.
    // Soft reset outranks the launch bit.
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl_reg <= cctr_pkg::MAIN_CONTROL_RESET;
        end else if (soft_reset) begin
            ctrl_reg <= cctr_pkg::MAIN_CONTROL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // One storage process per timing register; only the low 16 bits are kept.
    // Read frames never write, so readback
    // cannot disturb the timing it shows.
    genvar gi;
    generate
        for (gi = cctr_pkg::TIMING_FIRST; gi <= cctr_pkg::TIMING_LAST; gi++) begin : g_timing
            wire wr_this;
            assign wr_this = frame_event && !frame_is_read && (link_frame.addr == cctr_pkg::ADDR_W'(gi));
            always_ff @(posedge CLOCK or negedge RESET_N) begin
                if (!RESET_N) begin
                    timing_reg[gi] <= cctr_pkg::TIMING_RESET;
                end else if (soft_reset) begin
                    timing_reg[gi] <= cctr_pkg::TIMING_RESET;
                end else if (wr_this) begin
                    timing_reg[gi] <= link_frame.data[cctr_pkg::COUNT_W-1:0];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Pulse sequencer.
    // ------------------------------------------------------------------

    logic [cctr_pkg::DIV_W-1:0]   div_reg;
    logic [cctr_pkg::COUNT_W-1:0] count_reg;
    wire                          hold;
    wire                          tick;
    wire                          period_end;
    wire                          hit_sample_start;
    wire                          hit_sample_end;
    wire                          hit_emitter_on;
    wire                          hit_emitter_off;
    wire                          hit_ambient_start;

    // The divider trades an exact 4 MHz for a simple integer ratio of the system clock.
    // Holding also clears the divider, so the
    // first tick comes a full tick later.
    assign hold       = count_clear || soft_reset;
    assign tick       = (div_reg == cctr_pkg::SEQ_DIV_LAST);
    assign period_end = (count_reg >= PULSE_PERIOD_COUNT);

    // Every compare uses the same period-relative counter value.
    // Equality only: a count past the period
    // never fires.
    assign hit_sample_start  = (count_reg == timing_reg[cctr_pkg::IDX_SAMPLE_START]);
    assign hit_sample_end    = (count_reg == timing_reg[cctr_pkg::IDX_SAMPLE_END]);
    assign hit_emitter_on    = (count_reg == timing_reg[cctr_pkg::IDX_EMITTER_ON]);
    assign hit_emitter_off   = (count_reg == timing_reg[cctr_pkg::IDX_EMITTER_OFF]);
    assign hit_ambient_start = (count_reg == timing_reg[cctr_pkg::IDX_AMBIENT_START]);

    // Divider and period counter; the counter wraps to zero after the period count.
    // A period set below the count ends it
    // on the next tick.
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            div_reg   <= '0;
            count_reg <= '0;
        end else if (hold) begin
            div_reg   <= '0;
            count_reg <= '0;
        end else if (tick) begin
            div_reg   <= '0;
            count_reg <= period_end ? '0 : count_reg + 16'h0001;
        end else begin
            div_reg <= div_reg + 5'h01;
        end
    end

    // Window outputs change only on a sequencer tick or a hold, which clears them; a close on the same count wins.
    // TIMER_COUNT shows the count behind the
    // outputs, one cycle after the counter.
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            CH2_SAMPLE        <= 1'b0;
            CH2_EMITTER_ON    <= 1'b0;
            CH2_AMBIENT_START <= 1'b0;
            PERIOD_START      <= 1'b0;
            TIMER_COUNT       <= '0;
        end else if (hold) begin
            CH2_SAMPLE        <= 1'b0;
            CH2_EMITTER_ON    <= 1'b0;
            CH2_AMBIENT_START <= 1'b0;
            PERIOD_START      <= 1'b0;
            TIMER_COUNT       <= '0;
        end else begin
            TIMER_COUNT       <= count_reg;
            CH2_AMBIENT_START <= tick && hit_ambient_start;
            PERIOD_START      <= tick && (count_reg == '0);
            if (tick && hit_sample_end) begin
                CH2_SAMPLE <= 1'b0;
            end else if (tick && hit_sample_start) begin
                CH2_SAMPLE <= 1'b1;
            end
            if (tick && hit_emitter_off) begin
                CH2_EMITTER_ON <= 1'b0;
            end else if (tick && hit_emitter_on) begin
                CH2_EMITTER_ON <= 1'b1;
            end
        end
    end

endmodule

// *** hw/cctr_pkg.sv ***
// Shared constants and types for the control and emitter-two timing register bank.
package cctr_pkg;

    // Serial frame layout: one address byte followed by one 24-bit data word, MSB first.
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 24;
    localparam int FRAME_BITS = ADDR_W + DATA_W;
    localparam int BITCNT_W   = 6;
    localparam logic [BITCNT_W-1:0] BIT_ADDR_LAST  = 6'h07;
    localparam logic [BITCNT_W-1:0] BIT_DATA_FIRST = 6'h08;
    localparam logic [BITCNT_W-1:0] BIT_FRAME_LAST = 6'h1f;
    localparam logic [BITCNT_W-1:0] BIT_FRAME_DONE = 6'h20;

    // Register addresses.
    localparam logic [ADDR_W-1:0] ADDR_MAIN_CONTROL        = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CH2_SAMPLE_START    = 8'h01;
    localparam logic [ADDR_W-1:0] ADDR_CH2_SAMPLE_END      = 8'h02;
    localparam logic [ADDR_W-1:0] ADDR_CH2_EMITTER_ON      = 8'h03;
    localparam logic [ADDR_W-1:0] ADDR_CH2_EMITTER_OFF     = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_CH2_AMBIENT_START   = 8'h05;

    // Timing register array spans these indices, which equal their addresses.
    localparam int TIMING_FIRST = 1;
    localparam int TIMING_LAST  = 5;
    localparam int IDX_SAMPLE_START  = 1;
    localparam int IDX_SAMPLE_END    = 2;
    localparam int IDX_EMITTER_ON    = 3;
    localparam int IDX_EMITTER_OFF   = 4;
    localparam int IDX_AMBIENT_START = 5;

    // Main control bit positions.
    localparam int BIT_SOFT_RESET    = 3;
    localparam int BIT_DIAG_LAUNCH   = 2;
    localparam int BIT_COUNT_CLEAR   = 1;
    localparam int BIT_READ_ENABLE   = 0;
    localparam int CTRL_W            = 4;

    // Reset values.
    localparam logic [CTRL_W-1:0]  MAIN_CONTROL_RESET = 4'h0;
    localparam int                 COUNT_W            = 16;
    localparam logic [COUNT_W-1:0] TIMING_RESET       = 16'h0000;

    // Sequencer tick: the 4 MHz rate is derived from the system clock by an integer divider.
    localparam longint CLK_HZ  = 125000000;
    localparam longint SEQ_HZ  = 4000000;
    localparam int     DIV_W   = 5;
    localparam logic [DIV_W-1:0] SEQ_DIV_LAST = DIV_W'(CLK_HZ / SEQ_HZ - 1);

    // Fault check sequence length and fault status width.
    localparam longint DIAG_TIME_NS     = 16000;
    localparam longint CLK_PERIOD_NS    = 8;
    localparam int     DIAG_CYCLES      = int'(DIAG_TIME_NS / CLK_PERIOD_NS);
    localparam int     DIAG_W           = 16;
    localparam int     FAULT_W          = 13;

    // One received serial frame.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } cctr_frame_t;

    // Diagnostic sequence states.
    typedef enum logic [0:0] {
        DIAG_IDLE,
        DIAG_RUN
    } cctr_diag_state_t;

endpackage

// *** hw/cctr_spi_link.sv ***
// Serial port front end running on the link clock, with toggle events toward the system clock.
module cctr_spi_link (
    input  wire logic                       spi_clk,
    input  wire logic                       reset_n,
    input  wire logic                       cs_n,
    input  wire logic                       mosi,
    input  wire logic [cctr_pkg::DATA_W-1:0] rd_data,
    output logic [cctr_pkg::ADDR_W-1:0]     addr_word,
    output logic                            addr_toggle,
    output cctr_pkg::cctr_frame_t           frame_word,
    output logic                            frame_toggle,
    output logic                            miso,
    output logic                            miso_oe
);

    logic [cctr_pkg::BITCNT_W-1:0]   bit_cnt_reg;
    logic [cctr_pkg::FRAME_BITS-2:0] shift_reg;
    logic [cctr_pkg::DATA_W-1:0]     out_shift_reg;
    logic [cctr_pkg::FRAME_BITS-1:0] full_word;
    wire                             at_addr_last;
    wire                             at_frame_last;
    wire                             counting;

    // The link clock stands still between frames, so the frame's own select ends the count.
    assign counting      = (bit_cnt_reg != cctr_pkg::BIT_FRAME_DONE);
    assign at_addr_last  = (bit_cnt_reg == cctr_pkg::BIT_ADDR_LAST);
    assign at_frame_last = (bit_cnt_reg == cctr_pkg::BIT_FRAME_LAST);
    assign full_word     = {shift_reg, mosi};

    // Bit counter, cleared whenever the select is high.
    always_ff @(posedge spi_clk or posedge cs_n) begin
        if (cs_n) begin
            bit_cnt_reg <= '0;
        end else if (counting) begin
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
        end
    end

    // Input shifter and the two captured words; each capture flips its toggle.
    always_ff @(posedge spi_clk or negedge reset_n) begin
        if (!reset_n) begin
            shift_reg    <= '0;
            addr_word    <= '0;
            addr_toggle  <= 1'b0;
            frame_word   <= '0;
            frame_toggle <= 1'b0;
        end else begin
            shift_reg <= full_word[cctr_pkg::FRAME_BITS-2:0];
            if (at_addr_last) begin
                addr_word   <= full_word[cctr_pkg::ADDR_W-1:0];
                addr_toggle <= ~addr_toggle;
            end
            if (at_frame_last) begin
                frame_word   <= full_word;
                frame_toggle <= ~frame_toggle;
            end
        end
    end

    // Output data changes on the falling edge so the host samples it on the next rising edge.
    always_ff @(negedge spi_clk or negedge reset_n) begin
        if (!reset_n) begin
            miso          <= 1'b0;
            out_shift_reg <= '0;
        end else if (bit_cnt_reg == cctr_pkg::BIT_DATA_FIRST) begin
            miso          <= rd_data[cctr_pkg::DATA_W-1];
            out_shift_reg <= {rd_data[cctr_pkg::DATA_W-2:0], 1'b0};
        end else if (bit_cnt_reg > cctr_pkg::BIT_DATA_FIRST) begin
            miso          <= out_shift_reg[cctr_pkg::DATA_W-1];
            out_shift_reg <= {out_shift_reg[cctr_pkg::DATA_W-2:0], 1'b0};
        end else begin
            miso <= 1'b0;
        end
    end

    // The data pin is driven only while selected and released at once on deselect.
    always_ff @(negedge spi_clk or posedge cs_n) begin
        if (cs_n) begin
            miso_oe <= 1'b0;
        end else begin
            miso_oe <= 1'b1;
        end
    end

endmodule

// *** tb/cctr_top_asserts.sv ***
// Port-level checks of the register bank, bound into the top module.
module cctr_asserts #(
    parameter int DIAG_LEN = 8
) (
    input wire logic                         CLOCK,
    input wire logic                         RESET_N,
    input wire logic                         SPI_CS_N,
    input wire logic                         SPI_MISO_OE,
    input wire logic [cctr_pkg::COUNT_W-1:0] PULSE_PERIOD_COUNT,
    input wire logic [cctr_pkg::FAULT_W-1:0] FAULT_STATUS,
    input wire logic                         DIAG_BUSY,
    input wire logic [cctr_pkg::COUNT_W-1:0] TIMER_COUNT,
    input wire logic                         PERIOD_START,
    input wire logic                         CH2_AMBIENT_START
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] busy_reg;
    logic [15:0] busy_next;
    // Counts busy cycles, so a check that never finishes is caught early.
    assign busy_next = DIAG_BUSY ? busy_reg + 16'h1 : 16'h0;
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) busy_reg <= 16'h0;
        else busy_reg <= busy_next;
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);
    a_diag_length: assert property ($fell(DIAG_BUSY) |-> busy_reg == DIAG_LEN)
        else $error("fault check length wrong");
    a_diag_bound: assert property (busy_reg <= DIAG_LEN)
        else $error("fault check overran");
    a_fault_hold: assert property (!$stable(FAULT_STATUS) |-> $fell(DIAG_BUSY) || FAULT_STATUS == '0)
        else $error("fault status moved outside a check");
    a_cs_release: assert property (SPI_CS_N |-> !SPI_MISO_OE)
        else $error("serial output driven while deselected");
    a_period_zero: assert property (PERIOD_START |-> TIMER_COUNT == '0)
        else $error("period start at nonzero count");
    a_period_gap: assert property (PERIOD_START |=> !PERIOD_START [*8])
        else $error("period start pulses too close");
    a_ambient_gap: assert property (CH2_AMBIENT_START |=> !CH2_AMBIENT_START [*8])
        else $error("ambient start pulses too close");
    a_count_step: assert property (!$stable(TIMER_COUNT) |-> TIMER_COUNT == $past(TIMER_COUNT) + 16'h1 || TIMER_COUNT == '0)
        else $error("timer count skipped");
    a_count_range: assert property (TIMER_COUNT <= PULSE_PERIOD_COUNT)
        else $error("timer count beyond period");
endmodule
bind cctr_top cctr_asserts #(.DIAG_LEN(DIAG_LEN)) i_asserts (.CLOCK, .RESET_N, .SPI_CS_N, .SPI_MISO_OE,
    .PULSE_PERIOD_COUNT, .FAULT_STATUS, .DIAG_BUSY, .TIMER_COUNT, .PERIOD_START, .CH2_AMBIENT_START);

// *** tb/cctr_host.sv ***
// Serial host model: one address byte and one data word per frame, MSB first.
module cctr_host (
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso
);
    timeunit 1ns;
    timeprecision 100ps;
    // Clock low, select high between frames; select rises once at start to clear the link.
    initial begin
        sclk = 1'b0;
        cs_n = 1'b0;
        mosi = 1'b0;
        #1 cs_n = 1'b1;
    end
    // Bits launch on falling edges; reply bits are taken on rising edges.
    task automatic xfer(input logic [7:0] a, input logic [23:0] d, output logic [23:0] q);
        logic [31:0] w;
        w = {a, 8'h00, d[15:0]};
        q = 24'h0;
        cs_n = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            mosi = w[i];
            #62.5 sclk = 1'b1;
            if (i < 24) q[i] = miso;
            #62.5 sclk = 1'b0;
        end
        mosi = ~w[0];
        #62.5 cs_n = 1'b1;
        #125;
    endtask
endmodule

// *** tb/cctr_top_bench.sv ***
// Testbench: register frames, sequencer timing, fault check and resets.
module cctr_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TICK = int'(cctr_pkg::SEQ_DIV_LAST) + 1;
    localparam logic [15:0] VALS [1:5] = '{16'h0002, 16'h0005, 16'h0003, 16'h0006, 16'h0004};
    logic        clock = 1'b0;
    logic        reset_n = 1'b1;
    logic        sclk, cs_n, mosi, miso, miso_oe, miso_wire;
    logic [15:0] timer;
    logic [12:0] faults = 13'h1a5c;
    logic [12:0] status;
    logic        busy, pstart, smp, emit, amb;
    logic [23:0] rd;
    int          error_cnt = 0;
    int          checks_done = 0;
    int          rise [3];
    int          fall [3];
    // No pull on the reply line, so a released line reads as high impedance (z).
    always #4 clock = ~clock;
    assign miso_wire = miso_oe ? miso : 1'bz;
    cctr_top #(.DIAG_LEN(8)) i_dut (.CLOCK(clock), .RESET_N(reset_n), .SPI_CLK(sclk), .SPI_CS_N(cs_n),
        .SPI_MOSI(mosi), .SPI_MISO(miso), .SPI_MISO_OE(miso_oe), .PULSE_PERIOD_COUNT(16'h0009),
        .FAULT_INPUTS(faults), .FAULT_STATUS(status), .DIAG_BUSY(busy), .TIMER_COUNT(timer),
        .PERIOD_START(pstart), .CH2_SAMPLE(smp), .CH2_EMITTER_ON(emit), .CH2_AMBIENT_START(amb));
    cctr_host i_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_wire));
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Cycles from a period start to each edge of sample, emitter and ambient outputs.
    task automatic measure();
        logic [2:0] v;
        logic [2:0] pv;
        pv = 3'h0;
        @(posedge pstart);
        @(negedge clock);
        for (int t = 1; t < 10 * TICK; t++) begin
            @(negedge clock);
            v = {amb, emit, smp};
            for (int k = 0; k < 3; k++) begin
                if (v[k] && !pv[k]) rise[k] = t;
                if (!v[k] && pv[k]) fall[k] = t;
            end
            pv = v;
        end
    endtask
    // A hang cuts the run short well after all frames should have ended.
    initial begin
        #400us;
        error_cnt++;
        wrap_up();
    end
    // Main sequence; writes land before the host ends each frame.
    initial begin
        #1 reset_n = 1'b0;
        repeat (3) @(negedge clock);
        reset_n = 1'b1;
        repeat (3) @(negedge clock);
        check(24'(status), 24'h0);
        for (int a = 1; a <= 5; a++) i_host.xfer(8'(a), {8'h00, VALS[a]}, rd);
        i_host.xfer(8'h00, 24'h000001, rd);
        for (int p = 0; p < 2; p++) begin
            for (int a = 1; a <= 6; a++) begin
                i_host.xfer(8'(a), 24'h00aaaa, rd);
                check(rd, a < 6 ? {8'h00, VALS[a]} : 24'h0);
            end
        end
        measure();
        check(24'(rise[0]), 24'(VALS[1] * TICK));
        check(24'(fall[0]), 24'(VALS[2] * TICK));
        check(24'(rise[1]), 24'(VALS[3] * TICK));
        check(24'(fall[1]), 24'(VALS[4] * TICK));
        check(24'(rise[2]), 24'(VALS[5] * TICK));
        i_host.xfer(8'h00, 24'h000002, rd);
        repeat (2 * TICK) @(negedge clock);
        check({timer, smp, emit}, 24'h0);
        i_host.xfer(8'h01, 24'(VALS[1]), rd);
        check(rd, 24'h0);
        i_host.xfer(8'h00, 24'h000004, rd);
        check({busy, status}, 24'(13'h1a5c));
        @(negedge clock);
        faults = 13'h0123;
        repeat (12) @(negedge clock);
        check(24'(status), 24'(13'h1a5c));
        i_host.xfer(8'h00, 24'h000008, rd);
        i_host.xfer(8'h00, 24'h000001, rd);
        i_host.xfer(8'h01, 24'h000000, rd);
        check({rd[10:0], status}, 24'h0);
        wrap_up();
    end
endmodule
